// ### error_status_pkg.sv
// error status aggregator: shared constants, field layout and types
// assumes a 32-bit axi4-lite master and fault levels from the unit chain
package error_status_pkg;

   // ----------------------------------------
   // bus and register map
   // ----------------------------------------
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int REG_W = 16;
   localparam int WORD_SHIFT = 2;
   localparam int IDX_W = ADDR_W - WORD_SHIFT;
   // register indexes, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_SUMMARY = 6'h00;
   localparam logic [IDX_W-1:0] IDX_MEMORY = 6'h01;
   localparam logic [IDX_W-1:0] IDX_CONFIG = 6'h02;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   // ----------------------------------------
   // summary word bit positions
   // ----------------------------------------
   localparam int SUM_DEVICE = 0;
   localparam int SUM_CONFIG = 1;
   localparam int SUM_CHANNEL = 2;
   localparam int SUM_EXT_RAM = 3;
   localparam int SUM_LINK_STATUS = 4;
   localparam int SUM_LINK_ERROR = 6;
   localparam int SUM_UNIT_ERROR = 11;
   localparam int SUM_UNIT_ALARM = 13;
   localparam int SUM_UNIT_NOTIFY = 15;

   // ----------------------------------------
   // memory fault and configuration fault bits
   // ----------------------------------------
   localparam int MEM_NONVOLATILE = 4;
   localparam int MEM_SETTING = 6;
   localparam int MEM_REGISTRATION = 8;
   localparam int MEM_MODEL_DATA = 9;
   localparam int MEM_MODEL_MISMATCH = 12;
   localparam int CFG_UNKNOWN_UNIT = 0;
   localparam int CFG_NO_UNIT = 1;
   localparam int CFG_TOO_MANY = 2;
   localparam int CFG_UNRECOGNISED = 4;
   localparam int CFG_STARTUP = 5;
   localparam int CFG_LEFT_SIDE = 8;
   localparam int CFG_HEAD_RESET = 12;
   localparam int CFG_EMPTY_REG = 13;
   localparam int CFG_GROUP = 14;

   // ----------------------------------------
   // unit chain sizes
   // ----------------------------------------
   localparam int MAX_UNITS = 16;
   localparam int COUNT_W = 6;
   localparam int CHANNELS = 32;
   localparam int LINK_BITS = 16;
   localparam logic [COUNT_W-1:0] UNIT_LIMIT = 6'h10;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 6'h00;

   // fault levels gathered from the head unit and its chain
   typedef struct packed {
      logic mem_nonvolatile;
      logic mem_setting;
      logic mem_registration;
      logic mem_model_data;
      logic mem_model_mismatch;
      logic unit_unknown;
      logic unit_unrecognised;
      logic unit_startup;
      logic unit_left_side;
      logic head_reset_alone;
      logic group_invalid;
      logic cfg_registered;
      logic [COUNT_W-1:0] connected_count;
      logic [COUNT_W-1:0] registered_count;
      logic [CHANNELS-1:0] channel_error;
      logic ext_ram_error;
      logic [LINK_BITS-1:0] link_status;
      logic link_error;
      logic [MAX_UNITS-1:0] unit_error;
      logic [MAX_UNITS-1:0] unit_alarm;
      logic [MAX_UNITS-1:0] unit_peak_stale;
   } fault_in_t;

   typedef enum logic {WR_COLLECT, WR_RESPOND} wr_state_t;
   typedef enum logic {RD_IDLE, RD_RESPOND} rd_state_t;

endpackage : error_status_pkg

// ### error_status_aggregator.sv
// error status aggregator: three read-only status words over axi4-lite
// assumes fault levels arrive asynchronously and are quasi-static
//
// Behaviour
// - summary bit 0 set while any memory fault is present.
// - summary bit 1 set while unit configuration is faulty.
// - summary bit 2 set while any control channel reports an error.
// - summary bit 3 set on external working-memory fault in operation.
// - summary bit 4 set on any link status bit; no detail word touched.
// - summary bit 6 set on a programless link error.
// - summary bit 11 set when any basic unit reports an error.
// - summary bit 13 set when any basic unit has an active alarm.
// - summary bit 15 set when any unit peak current value is stale.
// - memory word flags bits 4, 6, 8, 9 and 12.
// - configuration bit 0 set when an unrecognised unit type is attached.
// - configuration bit 1 set when none registered and none connected.
// - configuration bit 2 set when connected unit count exceeds sixteen.
// - configuration bit 4 set when registered units cannot be recognised.
// - configuration bit 5 set on a configuration error during unit startup.
// - configuration bit 8 set when a unit sits left of the head unit.
// - configuration bit 12 set when only the head unit was reset.
// - configuration bit 13 set when registered with no basic units.
// - configuration bit 14 set when control group settings are invalid.
module error_status_aggregator (
   input wire logic clk_in, // 100 mhz clock
   input wire logic resetn_in, // synchronous reset, active low
   input wire error_status_pkg::fault_in_t faults_in, // raw fault levels
   input wire logic [error_status_pkg::ADDR_W-1:0] awaddr_in, // write address
   input wire logic [2:0] awprot_in, // write protection, ignored
   input wire logic awvalid_in, // write address valid
   output logic awready_out, // write address ready
   input wire logic [error_status_pkg::DATA_W-1:0] wdata_in, // write data, ignored
   input wire logic [3:0] wstrb_in, // write strobes, ignored
   input wire logic wvalid_in, // write data valid
   output logic wready_out, // write data ready
   output logic [1:0] bresp_out, // write response
   output logic bvalid_out, // write response valid
   input wire logic bready_in, // write response ready
   input wire logic [error_status_pkg::ADDR_W-1:0] araddr_in, // read address
   input wire logic [2:0] arprot_in, // read protection, ignored
   input wire logic arvalid_in, // read address valid
   output logic arready_out, // read address ready
   output logic [error_status_pkg::DATA_W-1:0] rdata_out, // read data
   output logic [1:0] rresp_out, // read response
   output logic rvalid_out, // read data valid
   input wire logic rready_in // read data ready
);
   import error_status_pkg::*;

   localparam int FLT_W = $bits(fault_in_t);

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [FLT_W-1:0] raw;
   logic [FLT_W-1:0] sync1_q;
   logic [FLT_W-1:0] sync2_q;
   logic [FLT_W-1:0] sync3_q;
   logic [FLT_W-1:0] flt_q;
   fault_in_t flt;

   assign raw = faults_in;
   assign flt = fault_in_t'(flt_q);

   // three stages per bit; a level counts once stages two and three agree.
   // counts are filtered bit by bit, so a count that moves may show a
   // transient mix for a few cycles; the chain only changes them rarely.
   genvar gi;
   generate
      for (gi = 0; gi < FLT_W; gi++) begin : g_sync
         always_ff @(posedge clk_in) begin
            if (!resetn_in) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
               sync3_q[gi] <= 1'b0;
               flt_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= raw[gi];
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
               if (sync2_q[gi] == sync3_q[gi]) begin
                  flt_q[gi] <= sync3_q[gi];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // status word assembly
   // ----------------------------------------
   logic [REG_W-1:0] mem_d;
   logic [REG_W-1:0] cfg_d;
   logic [REG_W-1:0] sum_d;
   logic [REG_W-1:0] mem_q;
   logic [REG_W-1:0] cfg_q;
   logic [REG_W-1:0] sum_q;

   // memory fault word; every other bit stays zero
   always_comb begin
      mem_d = REG_ZERO;
      mem_d[MEM_NONVOLATILE] = flt.mem_nonvolatile;
      mem_d[MEM_SETTING] = flt.mem_setting;
      mem_d[MEM_REGISTRATION] = flt.mem_registration;
      mem_d[MEM_MODEL_DATA] = flt.mem_model_data;
      mem_d[MEM_MODEL_MISMATCH] = flt.mem_model_mismatch;
   end

   // configuration fault word, derived from flags and unit counts
   always_comb begin
      cfg_d = REG_ZERO;
      cfg_d[CFG_UNKNOWN_UNIT] = flt.unit_unknown;
      cfg_d[CFG_NO_UNIT] = !flt.cfg_registered
         && (flt.registered_count == COUNT_ZERO)
         && (flt.connected_count == COUNT_ZERO);
      cfg_d[CFG_TOO_MANY] = flt.connected_count > UNIT_LIMIT;
      cfg_d[CFG_UNRECOGNISED] = flt.cfg_registered && flt.unit_unrecognised;
      cfg_d[CFG_STARTUP] = flt.unit_startup;
      cfg_d[CFG_LEFT_SIDE] = flt.unit_left_side;
      cfg_d[CFG_HEAD_RESET] = flt.head_reset_alone;
      cfg_d[CFG_EMPTY_REG] = flt.cfg_registered
         && (flt.registered_count == COUNT_ZERO);
      cfg_d[CFG_GROUP] = flt.group_invalid;
   end

   // summary word; built from the masked detail words so unused bits
   // can never leak into bits 0 and 1
   always_comb begin
      sum_d = REG_ZERO;
      sum_d[SUM_DEVICE] = |mem_d;
      sum_d[SUM_CONFIG] = |cfg_d;
      sum_d[SUM_CHANNEL] = |flt.channel_error;
      sum_d[SUM_EXT_RAM] = flt.ext_ram_error;
      sum_d[SUM_LINK_STATUS] = |flt.link_status;
      sum_d[SUM_LINK_ERROR] = flt.link_error;
      sum_d[SUM_UNIT_ERROR] = |flt.unit_error;
      sum_d[SUM_UNIT_ALARM] = |flt.unit_alarm;
      sum_d[SUM_UNIT_NOTIFY] = |flt.unit_peak_stale;
   end

   // status words are live levels, refreshed every cycle
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         mem_q <= REG_ZERO;
         cfg_q <= REG_ZERO;
         sum_q <= REG_ZERO;
      end else begin
         mem_q <= mem_d;
         cfg_q <= cfg_d;
         sum_q <= sum_d;
      end
   end

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   wr_state_t wr_state_q;
   logic aw_seen_q;
   logic w_seen_q;
   logic [IDX_W-1:0] wr_idx_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic aw_fire;
   logic w_fire;
   logic aw_done;
   logic w_done;
   logic [IDX_W-1:0] wr_idx;
   logic wr_mapped;

   assign aw_fire = awvalid_in && awready_q;
   assign w_fire = wvalid_in && wready_q;
   assign aw_done = aw_seen_q || aw_fire;
   assign w_done = w_seen_q || w_fire;
   assign wr_idx = aw_fire ? awaddr_in[ADDR_W-1:WORD_SHIFT] : wr_idx_q;
   assign wr_mapped = (wr_idx == IDX_SUMMARY) || (wr_idx == IDX_MEMORY)
      || (wr_idx == IDX_CONFIG);

   // address and data taken in either order, response once both are in.
   // writes stored nowhere
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         wr_state_q <= WR_COLLECT;
         aw_seen_q <= 1'b0;
         w_seen_q <= 1'b0;
         wr_idx_q <= IDX_SUMMARY;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         case (wr_state_q)
            WR_COLLECT: begin
               if (aw_fire) begin
                  aw_seen_q <= 1'b1;
                  awready_q <= 1'b0;
                  wr_idx_q <= awaddr_in[ADDR_W-1:WORD_SHIFT];
               end
               if (w_fire) begin
                  w_seen_q <= 1'b1;
                  wready_q <= 1'b0;
               end
               if (aw_done && w_done) begin
                  // read-only words accept and ignore; holes are refused
                  bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
                  bvalid_q <= 1'b1;
                  aw_seen_q <= 1'b0;
                  w_seen_q <= 1'b0;
                  awready_q <= 1'b0;
                  wready_q <= 1'b0;
                  wr_state_q <= WR_RESPOND;
               end
            end
            WR_RESPOND: begin
               if (bready_in) begin
                  bvalid_q <= 1'b0;
                  bresp_q <= RESP_OKAY;
                  awready_q <= 1'b1;
                  wready_q <= 1'b1;
                  wr_state_q <= WR_COLLECT;
               end
            end
            default: begin
               wr_state_q <= WR_COLLECT;
               aw_seen_q <= 1'b0;
               w_seen_q <= 1'b0;
               awready_q <= 1'b1;
               wready_q <= 1'b1;
               bvalid_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   rd_state_t rd_state_q;
   logic arready_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [DATA_W-1:0] rdata_q;
   logic [IDX_W-1:0] rd_idx;
   logic [DATA_W-1:0] rd_word;
   logic rd_mapped;

   assign rd_idx = araddr_in[ADDR_W-1:WORD_SHIFT];

   // word select; narrow words sit low, upper half reads zero
   always_comb begin
      rd_word = DATA_ZERO;
      rd_mapped = 1'b1;
      case (rd_idx)
         IDX_SUMMARY: rd_word[REG_W-1:0] = sum_q;
         IDX_MEMORY: rd_word[REG_W-1:0] = mem_q;
         IDX_CONFIG: rd_word[REG_W-1:0] = cfg_q;
         default: rd_mapped = 1'b0;
      endcase
   end

   // one read at a time; data captured at the address handshake so it
   // stays stable while the master stalls rready
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         rd_state_q <= RD_IDLE;
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= DATA_ZERO;
      end else begin
         case (rd_state_q)
            RD_IDLE: begin
               if (arvalid_in && arready_q) begin
                  arready_q <= 1'b0;
                  rvalid_q <= 1'b1;
                  rdata_q <= rd_word;
                  rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                  rd_state_q <= RD_RESPOND;
               end
            end
            RD_RESPOND: begin
               if (rready_in) begin
                  rvalid_q <= 1'b0;
                  rresp_q <= RESP_OKAY;
                  rdata_q <= DATA_ZERO;
                  arready_q <= 1'b1;
                  rd_state_q <= RD_IDLE;
               end
            end
            default: begin
               rd_state_q <= RD_IDLE;
               arready_q <= 1'b1;
               rvalid_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // outputs, all straight from flip-flops
   // ----------------------------------------
   assign awready_out = awready_q;
   assign wready_out = wready_q;
   assign bvalid_out = bvalid_q;
   assign bresp_out = bresp_q;
   assign arready_out = arready_q;
   assign rvalid_out = rvalid_q;
   assign rresp_out = rresp_q;
   assign rdata_out = rdata_q;

endmodule : error_status_aggregator

// ### unit_chain_model.sv
// expected status words and a behavioural model of the unit chain
// assumes the head unit samples fault levels that change off the clock grid
package status_expect_pkg;
   import error_status_pkg::*;

   // memory fault word from raw levels
   function automatic logic [REG_W-1:0] mem_exp(input fault_in_t f);
      logic [REG_W-1:0] w;
      w = REG_ZERO;
      w[MEM_NONVOLATILE] = f.mem_nonvolatile;
      w[MEM_SETTING] = f.mem_setting;
      w[MEM_REGISTRATION] = f.mem_registration;
      w[MEM_MODEL_DATA] = f.mem_model_data;
      w[MEM_MODEL_MISMATCH] = f.mem_model_mismatch;
      return w;
   endfunction : mem_exp

   // configuration fault word; count limit is strictly above sixteen
   function automatic logic [REG_W-1:0] cfg_exp(input fault_in_t f);
      logic [REG_W-1:0] w;
      w = REG_ZERO;
      w[CFG_UNKNOWN_UNIT] = f.unit_unknown;
      w[CFG_NO_UNIT] = !f.cfg_registered && f.registered_count == 0 && f.connected_count == 0;
      w[CFG_TOO_MANY] = f.connected_count > 16;
      w[CFG_UNRECOGNISED] = f.cfg_registered && f.unit_unrecognised;
      w[CFG_STARTUP] = f.unit_startup;
      w[CFG_LEFT_SIDE] = f.unit_left_side;
      w[CFG_HEAD_RESET] = f.head_reset_alone;
      w[CFG_EMPTY_REG] = f.cfg_registered && f.registered_count == 0;
      w[CFG_GROUP] = f.group_invalid;
      return w;
   endfunction : cfg_exp

   // summary word
   function automatic logic [REG_W-1:0] sum_exp(input fault_in_t f);
      logic [REG_W-1:0] w;
      w = REG_ZERO;
      w[SUM_DEVICE] = |mem_exp(f);
      w[SUM_CONFIG] = |cfg_exp(f);
      w[SUM_CHANNEL] = |f.channel_error;
      w[SUM_EXT_RAM] = f.ext_ram_error;
      w[SUM_LINK_STATUS] = |f.link_status;
      w[SUM_LINK_ERROR] = f.link_error;
      w[SUM_UNIT_ERROR] = |f.unit_error;
      w[SUM_UNIT_ALARM] = |f.unit_alarm;
      w[SUM_UNIT_NOTIFY] = |f.unit_peak_stale;
      return w;
   endfunction : sum_exp
endpackage : status_expect_pkg

module unit_chain_model (
   input wire error_status_pkg::fault_in_t levels_in, // levels the units should show
   output error_status_pkg::fault_in_t faults_out // levels seen at the head unit
);
   timeunit 1ns;
   timeprecision 100ps;
   // units switch off the clock grid, so the head unit must synchronise;
   // the #3 assign delay leaves faults_out at x until 3 ns, just before the first clock edge
   assign #3 faults_out = levels_in;
endmodule : unit_chain_model

// ### status_monitor.sv
// concurrent checks on the status aggregator ports
// assumes fault levels held quiet for eight cycles before a read counts
module status_monitor (
   input wire logic clk_in, // clock
   input wire logic resetn_in, // sync reset, active low
   input wire error_status_pkg::fault_in_t faults_in, // fault levels
   input wire logic [error_status_pkg::ADDR_W-1:0] araddr_in, // read address
   input wire logic arvalid_in, // read address valid
   input wire logic arready_out, // read address ready
   input wire logic awready_out, // write address ready
   input wire logic wready_out, // write data ready
   input wire logic [error_status_pkg::DATA_W-1:0] rdata_out, // read data
   input wire logic [1:0] rresp_out, // read response
   input wire logic rvalid_out, // read valid
   input wire logic rready_in, // read ready
   input wire logic [1:0] bresp_out, // write response
   input wire logic bvalid_out, // write response valid
   input wire logic bready_in // write response ready
);
   import error_status_pkg::*;
   import status_expect_pkg::*;
   logic [3:0] quiet_q;
   fault_in_t last_q;
   fault_in_t seen_q;
   logic [IDX_W-1:0] idx_q;
   logic ok_q;
   logic rd_sum;
   logic rd_mem;
   logic rd_cfg;
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   // count quiet cycles; the filter needs several before a read is trusted
   always_ff @(posedge clk_in) begin
      last_q <= faults_in;
      if (!resetn_in || faults_in !== last_q) begin
         quiet_q <= 4'h0;
      end else if (quiet_q != 4'hF) begin
         quiet_q <= quiet_q + 4'h1;
      end
   end
   // capture what a read should report at its address handshake
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ok_q <= 1'b0;
      end else if (arvalid_in && arready_out) begin
         ok_q <= quiet_q >= 4'h8;
         idx_q <= araddr_in[ADDR_W-1:WORD_SHIFT];
         seen_q <= faults_in;
      end
   end
   assign rd_sum = rvalid_out && ok_q && idx_q == IDX_SUMMARY;
   assign rd_mem = rvalid_out && ok_q && idx_q == IDX_MEMORY;
   assign rd_cfg = rvalid_out && ok_q && idx_q == IDX_CONFIG;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   chk_upper_zero: assert property (rvalid_out |-> rdata_out[31:16] == 16'h0000)
      else $error("upper read half not zero");
   chk_resp_map: assert property ($rose(rvalid_out) |->
      rresp_out == ((idx_q > IDX_CONFIG) ? RESP_SLVERR : RESP_OKAY))
      else $error("read response wrong for address");
   chk_sum_channel: assert property (rd_sum |-> rdata_out[2] == |seen_q.channel_error)
      else $error("channel summary wrong");
   chk_sum_extram: assert property (rd_sum |-> rdata_out[3] == seen_q.ext_ram_error)
      else $error("external memory summary wrong");
   chk_sum_link: assert property (rd_sum |-> rdata_out[6:4] ==
      {seen_q.link_error, 1'b0, |seen_q.link_status})
      else $error("link summary wrong");
   chk_sum_units: assert property (rd_sum |-> {rdata_out[15], rdata_out[13],
      rdata_out[11]} == {|seen_q.unit_peak_stale, |seen_q.unit_alarm, |seen_q.unit_error})
      else $error("unit summary wrong");
   chk_sum_detail: assert property (rd_sum |->
      rdata_out[1:0] == {|cfg_exp(seen_q), |mem_exp(seen_q)})
      else $error("detail summary wrong");
   chk_sum_unused: assert property (rd_sum |-> (rdata_out[15:0] & 16'h57A0) == 16'h0000)
      else $error("unused summary bit set");
   chk_mem_word: assert property (rd_mem |-> rdata_out[15:0] == mem_exp(seen_q))
      else $error("memory fault word wrong");
   chk_cfg_counts: assert property (rd_cfg |->
      (rdata_out[15:0] & 16'h2006) == (cfg_exp(seen_q) & 16'h2006))
      else $error("count derived config bits wrong");
   chk_cfg_flags: assert property (rd_cfg |->
      (rdata_out[15:0] & 16'hDFF9) == (cfg_exp(seen_q) & 16'hDFF9))
      else $error("config flag bits wrong");
   chk_rvalid_hold: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
      else $error("read answer dropped early");
   chk_bvalid_hold: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
      else $error("write answer dropped early");
   chk_ar_busy: assert property (rvalid_out |-> !arready_out)
      else $error("read address taken while answer pending");
   chk_w_busy: assert property (bvalid_out |-> !awready_out && !wready_out)
      else $error("write taken while response pending");
   cov_sum_read: cover property (rd_sum && rdata_out[1:0] == 2'h3);
   cov_slverr: cover property (rvalid_out && rresp_out == RESP_SLVERR);
   cov_write: cover property (bvalid_out && bready_in);
endmodule : status_monitor

bind error_status_aggregator status_monitor mon (.clk_in(clk_in), .resetn_in(resetn_in),
   .faults_in(faults_in), .araddr_in(araddr_in), .arvalid_in(arvalid_in),
   .arready_out(arready_out), .awready_out(awready_out), .wready_out(wready_out),
   .rdata_out(rdata_out), .rresp_out(rresp_out),
   .rvalid_out(rvalid_out), .rready_in(rready_in), .bresp_out(bresp_out),
   .bvalid_out(bvalid_out), .bready_in(bready_in));

// ### tb_error_status_aggregator.sv
// self-checking bench for the status aggregator
// assumes the unit chain model and the expectation package compiled first
module tb_error_status_aggregator;
   timeunit 1ns;
   timeprecision 100ps;
   import error_status_pkg::*;
   import status_expect_pkg::*;
   logic clk_in, resetn_in, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   fault_in_t want, faults;
   int fail_count, checks, seed;

   unit_chain_model chain (.levels_in(want), .faults_out(faults));
   error_status_aggregator DUT (.clk_in(clk_in), .resetn_in(resetn_in), .faults_in(faults),
      .awaddr_in(awaddr), .awprot_in(3'h0), .awvalid_in(awvalid), .awready_out(awready),
      .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready),
      .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr),
      .arprot_in(3'h0), .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
      .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready));

   // ----------------------------------------
   // compare and bus tasks
   // ----------------------------------------
   task automatic cmp_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t data got %h exp %h", $time, got, exp);
      end
   endtask : cmp_data
   task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t resp got %h exp %h", $time, got, exp);
      end
   endtask : cmp_resp
   // leading edge keeps back-to-back calls from assigning a signal twice
   task automatic axi_read(input logic [ADDR_W-1:0] a);
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      // random one-cycle stall so the slave must hold its answer
      if ($urandom_range(0, 1)) @(posedge clk_in);
      rready <= 1'b1;
      do @(posedge clk_in); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read
   task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'($urandom);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk_in);
         if (awready === 1'b1 && !aw_done) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !w_done) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(aw_done && w_done));
      // random one-cycle stall so the response must be held
      if ($urandom_range(0, 1)) @(posedge clk_in);
      bready <= 1'b1;
      do @(posedge clk_in); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write
   // let levels settle through the filter, then read every word and one unmapped
   task automatic check_words(input fault_in_t f);
      want <= f;
      repeat (10) @(posedge clk_in);
      for (int i = 0; i < 4; i++) begin
         axi_read(ADDR_W'(i * 4));
         cmp_data(d, i == 0 ? {16'h0000, sum_exp(f)} : i == 1 ? {16'h0000, mem_exp(f)} :
            i == 2 ? {16'h0000, cfg_exp(f)} : DATA_ZERO);
         cmp_resp(r, i < 3 ? RESP_OKAY : RESP_SLVERR);
      end
   endtask : check_words
   // random levels; wide vectors often cleared so their summary bits go both ways
   function automatic fault_in_t rand_faults();
      logic [127:0] raw;
      fault_in_t f;
      raw = {$urandom, $urandom, $urandom, $urandom};
      f = raw[$bits(fault_in_t)-1:0];
      f.connected_count = COUNT_W'($urandom_range(0, 20));
      f.registered_count = COUNT_W'($urandom_range(0, 3));
      if ($urandom_range(0, 1)) f.channel_error = '0;
      if ($urandom_range(0, 1)) f.link_status = '0;
      if ($urandom_range(0, 1)) f.unit_error = '0;
      if ($urandom_range(0, 1)) f.unit_alarm = '0;
      if ($urandom_range(0, 1)) f.unit_peak_stale = '0;
      return f;
   endfunction : rand_faults
   task automatic finish_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // the full run needs about 9 us
   initial begin
      #100us;
      fail_count++;
      finish_test();
   end
   initial begin
      fail_count = 0;
      checks = 0;
      seed = $urandom(40);
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'h0;
      want = '0;
      resetn_in = 1'b0;
      repeat (3) @(posedge clk_in);
      resetn_in <= 1'b1;
      // count boundaries: none at all, sixteen, seventeen, registered but empty
      check_words('0);
      want.connected_count = 6'h10;
      check_words(want);
      want.connected_count = 6'h11;
      check_words(want);
      want = '0;
      want.cfg_registered = 1'b1;
      want.unit_unrecognised = 1'b1;
      check_words(want);
      // writes are answered but change nothing
      for (int i = 0; i < 4; i++) begin
         axi_write(ADDR_W'(i * 4), $urandom);
         cmp_resp(r, i < 3 ? RESP_OKAY : RESP_SLVERR);
      end
      check_words(want);
      for (int n = 0; n < 30; n++) begin
         check_words(rand_faults());
      end
      finish_test();
   end
endmodule : tb_error_status_aggregator
